//--- logic/ctp_pkg.sv
// Constants shared by the compare-match and fast PWM timer.
package ctp_pkg;

  // ----------------------------------------------------------------
  // Waveform mode select encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_CTC_CMPA  = 4'h4;
  localparam logic [3:0] MODE_CTC_CAPT  = 4'hc;
  localparam logic [3:0] MODE_FAST_8B   = 4'h5;
  localparam logic [3:0] MODE_FAST_9B   = 4'h6;
  localparam logic [3:0] MODE_FAST_10B  = 4'h7;
  localparam logic [3:0] MODE_FAST_CAPT = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hf;

  // ----------------------------------------------------------------
  // Counter limits and fixed TOP values
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [15:0] CNT_STEP    = 16'h0001;
  localparam logic [15:0] TOP_FIX_8B  = 16'h00ff;
  localparam logic [15:0] TOP_FIX_9B  = 16'h01ff;
  localparam logic [15:0] TOP_FIX_10B = 16'h03ff;

  // ----------------------------------------------------------------
  // Output action encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler selects and division masks
  // ----------------------------------------------------------------
  localparam logic [2:0] PRE_STOP    = 3'h0;
  localparam logic [2:0] PRE_DIV1    = 3'h1;
  localparam logic [2:0] PRE_DIV8    = 3'h2;
  localparam logic [2:0] PRE_DIV64   = 3'h3;
  localparam logic [2:0] PRE_DIV256  = 3'h4;
  localparam logic [2:0] PRE_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV64   = 10'h03f;
  localparam logic [9:0] MASK_DIV256  = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
  localparam logic [9:0] PRE_STEP     = 10'h001;
  localparam logic [9:0] PRE_RESET    = 10'h000;

endpackage : ctp_pkg

//--- logic/ctp_prescaler.sv
// Prescaler that turns the I/O clock into a one-cycle timer tick.
module ctp_prescaler (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  ctp_tick_if.presc tick_port
);

  logic [9:0] div_ff;
  logic [9:0] nxt_div;
  logic       tick_ff;
  logic       nxt_tick;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // The divider runs freely, so a new select takes effect within one period.
  always_comb begin
    nxt_div = div_ff + ctp_pkg::PRE_STEP;
    case (tick_port.clock_select)
      ctp_pkg::PRE_DIV1:    nxt_tick = 1'b1;
      ctp_pkg::PRE_DIV8:    nxt_tick = (div_ff & ctp_pkg::MASK_DIV8) == ctp_pkg::MASK_DIV8;
      ctp_pkg::PRE_DIV64:   nxt_tick = (div_ff & ctp_pkg::MASK_DIV64) == ctp_pkg::MASK_DIV64;
      ctp_pkg::PRE_DIV256:  nxt_tick = (div_ff & ctp_pkg::MASK_DIV256) == ctp_pkg::MASK_DIV256;
      ctp_pkg::PRE_DIV1024: nxt_tick = div_ff == ctp_pkg::MASK_DIV1024;
      default:              nxt_tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_ff  <= ctp_pkg::PRE_RESET;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_port.tick = tick_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  div8_spacing_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick_ff && tick_port.clock_select == ctp_pkg::PRE_DIV8)
    |=> (!tick_ff || tick_port.clock_select != ctp_pkg::PRE_DIV8) [*7])
    else $error("divide by 8 tick came early");

endmodule : ctp_prescaler

//--- logic/ctp_tick_if.sv
// Carrier between the timer core and its prescaler.
interface ctp_tick_if;
  logic [2:0] clock_select;
  logic       tick;

  modport core  (output clock_select, input  tick);
  modport presc (input  clock_select, output tick);
endinterface : ctp_tick_if

//--- logic/ctp_timer_top.sv
// Compare-match clear and fast PWM 16-bit timer with two waveform channels.
module ctp_timer_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  waveform_mode_select_i,
  input  wire logic [2:0]  clock_select_i,
  input  wire logic [1:0]  output_action_a_i,
  input  wire logic [1:0]  output_action_b_i,
  input  wire logic        compare_a_wr_i,
  input  wire logic [15:0] compare_a_wdata_i,
  input  wire logic        compare_b_wr_i,
  input  wire logic [15:0] compare_b_wdata_i,
  input  wire logic        capture_top_wr_i,
  input  wire logic [15:0] capture_top_wdata_i,
  input  wire logic        overflow_clr_i,
  input  wire logic        compare_a_clr_i,
  input  wire logic        compare_b_clr_i,
  input  wire logic        capture_clr_i,
  input  wire logic        pin_direction_a_i,
  input  wire logic        pin_direction_b_i,
  input  wire logic        port_value_a_i,
  input  wire logic        port_value_b_i,
  output logic [15:0]      count_value_o,
  output logic [15:0]      compare_a_value_o,
  output logic [15:0]      capture_top_value_o,
  output logic             overflow_flag_o,
  output logic             compare_a_flag_o,
  output logic             compare_b_flag_o,
  output logic             capture_flag_o,
  output logic             wave_out_a_o,
  output logic             wave_out_b_o,
  output logic             pin_a_o,
  output logic             pin_a_oe_o,
  output logic             pin_b_o,
  output logic             pin_b_oe_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic is_fast(input logic [3:0] mode);
    return mode == ctp_pkg::MODE_FAST_8B || mode == ctp_pkg::MODE_FAST_9B ||
           mode == ctp_pkg::MODE_FAST_10B || mode == ctp_pkg::MODE_FAST_CAPT ||
           mode == ctp_pkg::MODE_FAST_CMPA;
  endfunction

  function automatic logic is_ctc(input logic [3:0] mode);
    return mode == ctp_pkg::MODE_CTC_CMPA || mode == ctp_pkg::MODE_CTC_CAPT;
  endfunction

  function automatic logic [15:0] fixed_mask(input logic [3:0] mode);
    if (mode == ctp_pkg::MODE_FAST_8B) begin
      return ctp_pkg::TOP_FIX_8B;
    end else if (mode == ctp_pkg::MODE_FAST_9B) begin
      return ctp_pkg::TOP_FIX_9B;
    end else if (mode == ctp_pkg::MODE_FAST_10B) begin
      return ctp_pkg::TOP_FIX_10B;
    end else begin
      return ctp_pkg::CNT_MAX;
    end
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] cmpa,
                                         input logic [15:0] capt);
    if (mode == ctp_pkg::MODE_CTC_CMPA || mode == ctp_pkg::MODE_FAST_CMPA) begin
      return cmpa;
    end else if (mode == ctp_pkg::MODE_CTC_CAPT || mode == ctp_pkg::MODE_FAST_CAPT) begin
      return capt;
    end else if (is_fast(mode)) begin
      return fixed_mask(mode);
    end else begin
      return ctp_pkg::CNT_MAX;
    end
  endfunction

  // Next level of a waveform register for one tick.
  function automatic logic wave_next(input logic fast, input logic toggle_ok,
                                     input logic [1:0] action, input logic match,
                                     input logic wrap, input logic cur);
    logic res;
    res = cur;
    if (fast) begin
      if (match) begin
        if (action == ctp_pkg::ACT_TOGGLE && toggle_ok) begin
          res = ~cur;
        end else if (action == ctp_pkg::ACT_CLEAR) begin
          res = 1'b1;
        end else if (action == ctp_pkg::ACT_SET) begin
          res = 1'b0;
        end
      end else if (wrap) begin
        if (action == ctp_pkg::ACT_CLEAR) begin
          res = 1'b0;
        end else if (action == ctp_pkg::ACT_SET) begin
          res = 1'b1;
        end
      end
    end else if (match) begin
      if (action == ctp_pkg::ACT_TOGGLE) begin
        res = ~cur;
      end else if (action == ctp_pkg::ACT_CLEAR) begin
        res = 1'b0;
      end else if (action == ctp_pkg::ACT_SET) begin
        res = 1'b1;
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  ctp_tick_if tick_bus ();

  assign tick_bus.clock_select = clock_select_i;

  ctp_prescaler u_prescaler (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .tick_port (tick_bus.presc)
  );

  // ----------------------------------------------------------------
  // Counter, compare registers, flags and outputs
  // ----------------------------------------------------------------
  logic [15:0] count_ff, nxt_count;
  logic [15:0] cmpa_buf_ff, nxt_cmpa_buf;
  logic [15:0] cmpa_act_ff, nxt_cmpa_act;
  logic [15:0] cmpb_buf_ff, nxt_cmpb_buf;
  logic [15:0] cmpb_act_ff, nxt_cmpb_act;
  logic [15:0] capt_ff, nxt_capt;
  logic        ovf_ff, nxt_ovf;
  logic        flag_a_ff, nxt_flag_a;
  logic        flag_b_ff, nxt_flag_b;
  logic        flag_c_ff, nxt_flag_c;
  logic        wave_a_ff, nxt_wave_a;
  logic        wave_b_ff, nxt_wave_b;
  logic        pin_a_ff, nxt_pin_a;
  logic        pin_b_ff, nxt_pin_b;
  logic        oe_a_ff, oe_b_ff;
  logic        tick, fast, clear_on_match_mode, at_top, match_a, match_b, toggle_ok, ovr_a, ovr_b;
  logic [15:0] top_now, wmask;

  always_comb begin
    tick      = tick_bus.tick;
    fast      = is_fast(waveform_mode_select_i);
    clear_on_match_mode       = is_ctc(waveform_mode_select_i);
    toggle_ok = waveform_mode_select_i == ctp_pkg::MODE_FAST_CMPA;
    top_now   = top_of(waveform_mode_select_i, cmpa_act_ff, capt_ff);
    wmask     = fixed_mask(waveform_mode_select_i);
    at_top    = count_ff == top_now;
    match_a   = count_ff == cmpa_act_ff;
    match_b   = count_ff == cmpb_act_ff;
    nxt_count    = count_ff;
    nxt_cmpa_buf = cmpa_buf_ff;
    nxt_cmpa_act = cmpa_act_ff;
    nxt_cmpb_buf = cmpb_buf_ff;
    nxt_cmpb_act = cmpb_act_ff;
    nxt_capt     = capt_ff;
    nxt_wave_a   = wave_a_ff;
    nxt_wave_b   = wave_b_ff;
    // Clears are applied first so that a set in the same cycle wins.
    nxt_ovf    = ovf_ff & ~overflow_clr_i;
    nxt_flag_a = flag_a_ff & ~compare_a_clr_i;
    nxt_flag_b = flag_b_ff & ~compare_b_clr_i;
    nxt_flag_c = flag_c_ff & ~capture_clr_i;
    if (compare_a_wr_i) begin
      nxt_cmpa_buf = compare_a_wdata_i & wmask;
      if (!fast) begin
        nxt_cmpa_act = compare_a_wdata_i & wmask;
      end
    end
    if (compare_b_wr_i) begin
      nxt_cmpb_buf = compare_b_wdata_i & wmask;
      if (!fast) begin
        nxt_cmpb_act = compare_b_wdata_i & wmask;
      end
    end
    if (capture_top_wr_i) begin
      nxt_capt = capture_top_wdata_i;
    end
    if (tick) begin
      if (fast && at_top) begin
        nxt_count    = ctp_pkg::CNT_BOTTOM;
        nxt_ovf      = 1'b1;
        nxt_cmpa_act = cmpa_buf_ff;
        nxt_cmpb_act = cmpb_buf_ff;
        if (waveform_mode_select_i == ctp_pkg::MODE_FAST_CAPT) begin
          nxt_flag_c = 1'b1;
        end
      end else if (clear_on_match_mode && at_top) begin
        nxt_count = ctp_pkg::CNT_BOTTOM;
        if (waveform_mode_select_i == ctp_pkg::MODE_CTC_CAPT) begin
          nxt_flag_c = 1'b1;
        end
      end else begin
        nxt_count = count_ff + ctp_pkg::CNT_STEP;
      end
      if (!fast && count_ff == ctp_pkg::CNT_MAX) begin
        nxt_ovf = 1'b1;
      end
      if (match_a) begin
        nxt_flag_a = 1'b1;
      end
      if (match_b) begin
        nxt_flag_b = 1'b1;
      end
      nxt_wave_a = wave_next(fast, toggle_ok, output_action_a_i, match_a, at_top, wave_a_ff);
      nxt_wave_b = wave_next(fast, 1'b0, output_action_b_i, match_b, at_top, wave_b_ff);
    end
    // Toggle in fast PWM is only a waveform on channel A in mode 15.
    ovr_a = output_action_a_i != ctp_pkg::ACT_NONE &&
            !(fast && output_action_a_i == ctp_pkg::ACT_TOGGLE && !toggle_ok);
    ovr_b = output_action_b_i != ctp_pkg::ACT_NONE &&
            !(fast && output_action_b_i == ctp_pkg::ACT_TOGGLE);
    nxt_pin_a = ovr_a ? nxt_wave_a : port_value_a_i;
    nxt_pin_b = ovr_b ? nxt_wave_b : port_value_b_i;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff    <= ctp_pkg::CNT_BOTTOM;
      cmpa_buf_ff <= ctp_pkg::CNT_BOTTOM;
      cmpa_act_ff <= ctp_pkg::CNT_BOTTOM;
      cmpb_buf_ff <= ctp_pkg::CNT_BOTTOM;
      cmpb_act_ff <= ctp_pkg::CNT_BOTTOM;
      capt_ff     <= ctp_pkg::CNT_BOTTOM;
      ovf_ff      <= 1'b0;
      flag_a_ff   <= 1'b0;
      flag_b_ff   <= 1'b0;
      flag_c_ff   <= 1'b0;
      wave_a_ff   <= 1'b0;
      wave_b_ff   <= 1'b0;
      pin_a_ff    <= 1'b0;
      pin_b_ff    <= 1'b0;
      oe_a_ff     <= 1'b0;
      oe_b_ff     <= 1'b0;
    end else begin
      count_ff    <= nxt_count;
      cmpa_buf_ff <= nxt_cmpa_buf;
      cmpa_act_ff <= nxt_cmpa_act;
      cmpb_buf_ff <= nxt_cmpb_buf;
      cmpb_act_ff <= nxt_cmpb_act;
      capt_ff     <= nxt_capt;
      ovf_ff      <= nxt_ovf;
      flag_a_ff   <= nxt_flag_a;
      flag_b_ff   <= nxt_flag_b;
      flag_c_ff   <= nxt_flag_c;
      wave_a_ff   <= nxt_wave_a;
      wave_b_ff   <= nxt_wave_b;
      pin_a_ff    <= nxt_pin_a;
      pin_b_ff    <= nxt_pin_b;
      oe_a_ff     <= pin_direction_a_i;
      oe_b_ff     <= pin_direction_b_i;
    end
  end

  assign count_value_o       = count_ff;
  assign compare_a_value_o   = cmpa_act_ff;
  assign capture_top_value_o = capt_ff;
  assign overflow_flag_o     = ovf_ff;
  assign compare_a_flag_o    = flag_a_ff;
  assign compare_b_flag_o    = flag_b_ff;
  assign capture_flag_o      = flag_c_ff;
  assign wave_out_a_o        = wave_a_ff;
  assign wave_out_b_o        = wave_b_ff;
  assign pin_a_o             = pin_a_ff;
  assign pin_a_oe_o          = oe_a_ff;
  assign pin_b_o             = pin_b_ff;
  assign pin_b_oe_o          = oe_b_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ctc_top_clear_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && clear_on_match_mode && at_top) |=> count_ff == ctp_pkg::CNT_BOTTOM)
    else $error("compare-match mode did not clear at TOP");

  ctc_top_flag_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && waveform_mode_select_i == ctp_pkg::MODE_CTC_CAPT && at_top) |=> flag_c_ff)
    else $error("capture flag missing at TOP");

  ctc_toggle_out_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && clear_on_match_mode && match_a && output_action_a_i == ctp_pkg::ACT_TOGGLE)
    |=> wave_a_ff != $past(wave_a_ff))
    else $error("output A did not toggle on match");

  pin_hidden_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !pin_direction_a_i |=> !pin_a_oe_o)
    else $error("pin A driven while direction is input");

  ctc_overflow_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && clear_on_match_mode && count_ff == ctp_pkg::CNT_MAX) |=> ovf_ff && count_ff == ctp_pkg::CNT_BOTTOM)
    else $error("overflow not flagged at MAX to zero");

  fast_wrap_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && fast && at_top) |=> count_ff == ctp_pkg::CNT_BOTTOM && ovf_ff)
    else $error("fast PWM did not wrap at TOP");

  fast_flags_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && waveform_mode_select_i == ctp_pkg::MODE_FAST_CMPA && at_top)
    |=> flag_a_ff && ovf_ff)
    else $error("mode 15 TOP flags missing");

  buffer_load_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && fast && at_top) |=> cmpa_act_ff == $past(cmpa_buf_ff))
    else $error("compare A buffer not loaded at TOP");

  fixed_mask_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (compare_a_wr_i && waveform_mode_select_i == ctp_pkg::MODE_FAST_8B)
    |=> (cmpa_buf_ff & ~ctp_pkg::TOP_FIX_8B) == ctp_pkg::CNT_BOTTOM)
    else $error("high compare bits not masked");

  fast_noninv_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && fast && !match_a && at_top && output_action_a_i == ctp_pkg::ACT_CLEAR)
    |=> !wave_a_ff)
    else $error("non-inverting output not cleared at TOP");

endmodule : ctp_timer_top

//--- test/ctp_pin_load.sv
// External load on one timer pin, resolving the wire level seen outside.
module ctp_pin_load (
  input  wire logic pin_i,
  input  wire logic oe_i,
  output logic      level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  // An undriven pin floats, so show the inverse of the last driven level, never a stale copy.
  always @(pin_i or oe_i) if (oe_i) last = pin_i;
  assign level_o = oe_i ? pin_i : ~last;
endmodule // ctp_pin_load

//--- test/tb_top.sv
// Directed testbench for the compare-match and fast PWM timer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rst_i = 1'b1;
  logic [3:0] mode = 4'h0;
  logic [2:0] csel = 3'h0;
  logic [1:0] act_a = 2'h0, act_b = 2'h0;
  logic wr_a = 0, wr_b = 0, wr_c = 0, clr_o = 0, clr_c = 0, clr_a = 0, clr_b = 0;
  logic dir_a = 0, dir_b = 0, pv_a = 0;
  logic [15:0] wd = 16'h0000, cnt, cmpa, capt, n;
  logic ovf, fa, fb, fc, wa, wb, pa, pae, pb, pbe, lvl_a, lvl_b;
  int fails = 0, cmp_count = 0, e;
  int div[5] = '{1, 8, 64, 256, 1024};
  logic [2:0] sel[5] = '{ctp_pkg::PRE_DIV1, ctp_pkg::PRE_DIV8, ctp_pkg::PRE_DIV64,
                         ctp_pkg::PRE_DIV256, ctp_pkg::PRE_DIV1024};
  logic [15:0] cv[3] = '{16'h0003, 16'h0009, 16'h0000};
  always #12.5 mclk_i = ~mclk_i;
  ctp_timer_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .waveform_mode_select_i(mode),
    .clock_select_i(csel), .output_action_a_i(act_a), .output_action_b_i(act_b),
    .compare_a_wr_i(wr_a), .compare_a_wdata_i(wd), .compare_b_wr_i(wr_b),
    .compare_b_wdata_i(wd), .capture_top_wr_i(wr_c), .capture_top_wdata_i(wd),
    .overflow_clr_i(clr_o), .compare_a_clr_i(clr_a), .compare_b_clr_i(clr_b),
    .capture_clr_i(clr_c), .pin_direction_a_i(dir_a), .pin_direction_b_i(dir_b),
    .port_value_a_i(pv_a), .port_value_b_i(1'b0), .count_value_o(cnt),
    .compare_a_value_o(cmpa), .capture_top_value_o(capt), .overflow_flag_o(ovf),
    .compare_a_flag_o(fa), .compare_b_flag_o(fb), .capture_flag_o(fc), .wave_out_a_o(wa),
    .wave_out_b_o(wb), .pin_a_o(pa), .pin_a_oe_o(pae), .pin_b_o(pb), .pin_b_oe_o(pbe));
  ctp_pin_load load_a (.pin_i(pa), .oe_i(pae), .level_o(lvl_a));
  ctp_pin_load load_b (.pin_i(pb), .oe_i(pbe), .level_o(lvl_b));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task tick(); @(posedge mclk_i); #2; endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input int s, input logic [15:0] d);
    wd = d; wr_a = (s == 0); wr_b = (s == 1); wr_c = (s == 2); tick();
    wr_a = 0; wr_b = 0; wr_c = 0; tick();
  endtask
  task cfg(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab);
    mode = m; csel = ctp_pkg::PRE_DIV1; act_a = aa; act_b = ab; tick();
  endtask
  task pulse_ovf_clr(); clr_o = 1; tick(); clr_o = 0; tick(); endtask
  task wait_cnt(input logic [15:0] v);
    for (int i = 0; i < 70000 && cnt !== v; i++) tick();
    chk(cnt, v);
  endtask
  // Ticks between two successive changes of output A, after syncing on two changes.
  // The first change may still come from a tick of the previous divider setting.
  task edge_gap(output logic [15:0] g);
    logic v;
    g = 0;
    for (int s = 0; s < 2; s++) begin
      v = wa;
      for (int i = 0; i < 5000 && wa === v; i++) tick();
    end
    v = wa;
    for (int i = 0; i < 5000 && wa === v; i++) begin tick(); g++; end
  endtask
  task report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_i);
    #2 rst_i = 0;
    tick();
    cfg(ctp_pkg::MODE_CTC_CMPA, ctp_pkg::ACT_TOGGLE, ctp_pkg::ACT_NONE);
    dir_a = 1;
    wr(0, 16'h0000);
    edge_gap(n); chk(n, 16'h0001);
    wr(0, 16'h0001);
    for (int k = 0; k < 5; k++) begin
      csel = sel[k];
      edge_gap(n); chk(n, 16'(div[k] * 2));
    end
    csel = ctp_pkg::PRE_DIV1;
    clr_a = 1; tick(); clr_a = 0;
    edge_gap(n); chk(fa, 1'b1);
    chk(lvl_a, wa);
    dir_a = 0; tick(); tick(); chk(pae, 1'b0);
    dir_a = 1; act_a = ctp_pkg::ACT_NONE; pv_a = 1; tick(); tick();
    n = wa; chk(lvl_a, 1'b1);
    pv_a = 0; repeat (6) tick(); chk(lvl_a, 1'b0);
    chk(wa, n);
    cfg(ctp_pkg::MODE_CTC_CAPT, ctp_pkg::ACT_NONE, ctp_pkg::ACT_NONE);
    wr(2, 16'h0005); chk(capt, 16'h0005);
    clr_c = 1; tick(); clr_c = 0;
    wait_cnt(16'h0005); tick(); chk(cnt, 16'h0000);
    chk(fc, 1'b1);
    cfg(ctp_pkg::MODE_CTC_CMPA, ctp_pkg::ACT_NONE, ctp_pkg::ACT_NONE);
    wr(0, 16'h0100); wait_cnt(16'h0040);
    wr(0, 16'h0010); pulse_ovf_clr();
    wait_cnt(16'hffff); chk(ovf, 1'b0);
    tick(); chk(cnt, 16'h0000);
    chk(ovf, 1'b1);
    cfg(ctp_pkg::MODE_FAST_8B, ctp_pkg::ACT_NONE, ctp_pkg::ACT_NONE);
    pulse_ovf_clr();
    wr(0, 16'h1234); chk(cmpa, 16'h0010);
    wait_cnt(16'h00ff); tick(); chk(cnt, 16'h0000);
    chk(cmpa, 16'h0034);
    chk(ovf, 1'b1);
    cfg(ctp_pkg::MODE_FAST_CMPA, ctp_pkg::ACT_TOGGLE, ctp_pkg::ACT_NONE);
    wr(0, 16'h0004); wr(2, 16'h0009);
    edge_gap(n); chk(n, 16'h0005);
    wait_cnt(16'h0002); wr(0, 16'h0007); chk(cmpa, 16'h0004);
    clr_a = 1; wait_cnt(16'h0000); clr_a = 0; chk(cmpa, 16'h0007);
    chk(fa, 1'b1);
    cfg(ctp_pkg::MODE_FAST_CAPT, ctp_pkg::ACT_CLEAR, ctp_pkg::ACT_CLEAR);
    dir_b = 1;
    for (int k = 0; k < 3; k++) begin
      wr(1, cv[k]);
      for (int a = 2; a < 4; a++) begin
        act_b = 2'(a); repeat (20) tick();
        e = (cv[k] == 16'h0009) ? 10 : 9 - cv[k];
        if (a == 3) e = 10 - e;
        n = 0;
        for (int i = 0; i < 10; i++) begin tick(); if (wb === 1'b1) n++; end
        chk(n, 16'(e));
      end
    end
    chk(lvl_b, wb);
    wr(1, 16'h0001); wait_cnt(16'h0000);
    clr_b = 1; tick(); clr_b = 0; chk(fb, 1'b0);
    tick(); chk(fb, 1'b1);
    wr(2, 16'h0003); chk(capt, 16'h0003);
    wait_cnt(16'h0003); tick(); chk(cnt, 16'h0000);
    report_and_stop();
  end
  initial begin
    #(25ns * 100000);
    fails++;
    report_and_stop();
  end
endmodule // tb_top
